//--- shared/hsl_pkg.sv
package hsl_pkg;
  // host port register map
  localparam logic [7:0] HSL_ADDR_SEQ_CTRL = 8'h19;
  localparam logic [7:0] HSL_ADDR_OD_OFFSET = 8'h1A;
  localparam logic [7:0] HSL_ADDR_SP_OFFSET = 8'h1B;
  localparam logic [7:0] HSL_REG_RESET = 8'h00;
  localparam logic [7:0] HSL_READ_UNMAPPED = 8'h00;
  // main repeat field, bits 2-0
  localparam int HSL_MAIN_LSB = 0;
  localparam int HSL_MAIN_W = 3;
  localparam logic [2:0] HSL_MAIN_INFINITE = 3'h7;
  localparam logic [2:0] HSL_PASS_FIRST = 3'h0;
  // slot table
  localparam int HSL_SLOTS = 8;
  localparam int HSL_SLOT_IDX_W = 3;
  localparam int HSL_SLOT_W = 8;
  localparam int HSL_ID_W = 7;
  localparam int HSL_REP_W = 2;
  localparam logic [2:0] HSL_FIRST_SLOT = 3'h0;
  localparam logic [2:0] HSL_LAST_SLOT = 3'h7;
  localparam logic [6:0] HSL_NULL_ID = 7'h00;
  localparam logic [1:0] HSL_REP_FIRST = 2'h0;
  // durations in ms, sample period in ms
  localparam int HSL_DUR_W = 16;
  localparam int HSL_PER_W = 8;
  localparam int HSL_SUM_W = 18;
  localparam logic [15:0] HSL_DUR_MAX = 16'hFFFF;
  localparam logic [15:0] HSL_DUR_ZERO = 16'h0000;
  typedef enum logic [1:0] {HSL_IDLE, HSL_PLAY, HSL_WAIT} hsl_state_t;
endpackage

//--- design/hsl_seq_loop_offset.sv
`timescale 1ns/1ps
// Notes on behaviour
// (RL1) main repeat field 0 plays sequence once; 1 to 6 add that many passes.
// (RL2) main repeat 7 loops forever; host stops it by trigger or start bit.
// (RL3) a pass plays slots in order, ending at zero identifier or after slot eight.
// (RL4) overdrive offset is signed, scaled by sample period, adjusts overdrive length.
// (RL5) overdrive portion is the sample or samples at the waveform maximum.
// (RL6) overdrive offset applies only in open loop; closed loop ignores it.
// (RL7) positive samples outside overdrive count as positive sustain.
// (RL8) sustain offset is signed, scaled by sample period, adjusts positive sustain length.
// (RL9) slot repeat count N plays that slot N+1 times before advancing.
// (RL10) negative offset larger than portion length clamps duration to zero.
module hsl_seq_loop_offset (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  input wire logic goBit,
  input wire logic stopTrig,
  input wire logic [hsl_pkg::HSL_SLOTS*hsl_pkg::HSL_SLOT_W-1:0] slotIdFlat,
  input wire logic [hsl_pkg::HSL_SLOTS*hsl_pkg::HSL_REP_W-1:0] slotRepFlat,
  input wire logic effectDone,
  output logic effectStart,
  output logic [hsl_pkg::HSL_ID_W-1:0] effectId,
  output logic [hsl_pkg::HSL_SLOT_IDX_W-1:0] slotIndex,
  output logic seqBusy,
  output logic seqDone,
  input wire logic openLoop,
  input wire logic [hsl_pkg::HSL_PER_W-1:0] samplePeriod,
  input wire logic sampleValid,
  input wire logic signed [7:0] sampleValue,
  input wire logic signed [7:0] waveMax,
  output logic isOverdrive,
  output logic isPosSustain,
  input wire logic [hsl_pkg::HSL_DUR_W-1:0] overdriveBase,
  input wire logic [hsl_pkg::HSL_DUR_W-1:0] posSustainBase,
  output logic [hsl_pkg::HSL_DUR_W-1:0] overdriveDuration,
  output logic [hsl_pkg::HSL_DUR_W-1:0] posSustainDuration
);
  import hsl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [HSL_ID_W-1:0] slotId(
    input logic [HSL_SLOTS*HSL_SLOT_W-1:0] flat,
    input logic [HSL_SLOT_IDX_W-1:0] idx);
    slotId = flat[idx*HSL_SLOT_W +: HSL_ID_W];
  endfunction

  function automatic logic [HSL_REP_W-1:0] slotRep(
    input logic [HSL_SLOTS*HSL_REP_W-1:0] flat,
    input logic [HSL_SLOT_IDX_W-1:0] idx);
    slotRep = flat[idx*HSL_REP_W +: HSL_REP_W];
  endfunction

  // widened signed sum keeps the negative case visible before clamping
  function automatic logic [HSL_DUR_W-1:0] adjDur(
    input logic [HSL_DUR_W-1:0] base,
    input logic signed [7:0] off,
    input logic [HSL_PER_W-1:0] per);
    logic signed [HSL_SUM_W-1:0] prod;
    logic signed [HSL_SUM_W-1:0] sum;
    prod = HSL_SUM_W'(off) * $signed({{(HSL_SUM_W-HSL_PER_W){1'b0}}, per});
    sum = $signed({{(HSL_SUM_W-HSL_DUR_W){1'b0}}, base}) + prod;
    // (RL10) clamp at zero
    if (sum < 0) begin
      adjDur = HSL_DUR_ZERO;
    end else if (sum > $signed({{(HSL_SUM_W-HSL_DUR_W){1'b0}}, HSL_DUR_MAX})) begin
      adjDur = HSL_DUR_MAX;
    end else begin
      adjDur = sum[HSL_DUR_W-1:0];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] seqCtrl;
  logic signed [7:0] overdriveOffset;
  logic signed [7:0] posSustainOffset;
  wire logic [HSL_MAIN_W-1:0] mainRepeatCount = seqCtrl[HSL_MAIN_LSB +: HSL_MAIN_W];
  wire logic selCtrl = (regAddr == HSL_ADDR_SEQ_CTRL);
  wire logic selOd = (regAddr == HSL_ADDR_OD_OFFSET);
  wire logic selSp = (regAddr == HSL_ADDR_SP_OFFSET);
  wire logic [7:0] rdMux = selCtrl ? seqCtrl :
                           selOd ? overdriveOffset :
                           selSp ? posSustainOffset : HSL_READ_UNMAPPED;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      seqCtrl <= HSL_REG_RESET;
      overdriveOffset <= HSL_REG_RESET;
      posSustainOffset <= HSL_REG_RESET;
      regRdData <= HSL_REG_RESET;
    end else begin
      if (regWrEn && selCtrl) seqCtrl <= regWrData;
      if (regWrEn && selOd) overdriveOffset <= regWrData;
      if (regWrEn && selSp) posSustainOffset <= regWrData;
      if (regRdEn) regRdData <= rdMux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  hsl_state_t state;
  logic [HSL_SLOT_IDX_W-1:0] slot;
  logic [HSL_REP_W-1:0] repDone;
  logic [HSL_MAIN_W-1:0] passCount;
  logic goPrev;
  wire logic goRise = goBit && !goPrev;
  wire logic [HSL_ID_W-1:0] curId = slotId(slotIdFlat, slot);
  wire logic [HSL_REP_W-1:0] curRep = slotRep(slotRepFlat, slot);
  wire logic stopNow = stopTrig || !goBit;
  // (RL3) pass ends at null id or after last slot
  wire logic endPass = !stopNow &&
                       ((state == HSL_PLAY && curId == HSL_NULL_ID) ||
                        (state == HSL_WAIT && effectDone && repDone == curRep &&
                         slot == HSL_LAST_SLOT));
  // (RL1) more passes owed while count below main repeat
  wire logic morePasses = (mainRepeatCount == HSL_MAIN_INFINITE) ||
                          (passCount != mainRepeatCount);

  assign seqBusy = (state != HSL_IDLE);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= HSL_IDLE;
      slot <= HSL_FIRST_SLOT;
      repDone <= HSL_REP_FIRST;
      passCount <= HSL_PASS_FIRST;
      goPrev <= 1'b0;
      effectStart <= 1'b0;
      effectId <= HSL_NULL_ID;
      slotIndex <= HSL_FIRST_SLOT;
      seqDone <= 1'b0;
    end else begin
      goPrev <= goBit;
      effectStart <= 1'b0;
      seqDone <= 1'b0;
      case (state)
        HSL_IDLE: begin
          if (goRise && !stopTrig) begin
            state <= HSL_PLAY;
            slot <= HSL_FIRST_SLOT;
            repDone <= HSL_REP_FIRST;
            passCount <= HSL_PASS_FIRST;
          end
        end
        HSL_PLAY: begin
          // (RL2) host stop ends even an endless loop
          if (stopNow) begin
            state <= HSL_IDLE;
          end else if (endPass) begin
            // (RL2) value seven never runs out of passes
            if (morePasses) begin
              slot <= HSL_FIRST_SLOT;
              repDone <= HSL_REP_FIRST;
              if (mainRepeatCount != HSL_MAIN_INFINITE) passCount <= passCount + 3'h1;
            end else begin
              state <= HSL_IDLE;
              seqDone <= 1'b1;
            end
          end else begin
            effectStart <= 1'b1;
            effectId <= curId;
            slotIndex <= slot;
            state <= HSL_WAIT;
          end
        end
        HSL_WAIT: begin
          if (stopNow) begin
            state <= HSL_IDLE;
          end else if (effectDone) begin
            state <= HSL_PLAY;
            // (RL9) replay slot until N+1 plays
            if (repDone != curRep) begin
              repDone <= repDone + 2'h1;
            end else begin
              repDone <= HSL_REP_FIRST;
              // (RL3) wrap to first slot after the eighth
              slot <= slot + 3'h1;
              if (endPass && morePasses && mainRepeatCount != HSL_MAIN_INFINITE)
                passCount <= passCount + 3'h1;
              if (endPass && !morePasses) begin
                state <= HSL_IDLE;
                seqDone <= 1'b1;
              end
            end
          end
        end
        default: state <= HSL_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // (RL5) overdrive is any sample at the waveform maximum
  wire logic sampleOd = (sampleValue == waveMax);
  // (RL7) remaining positive samples are sustain
  wire logic sampleSp = (sampleValue > 0) && !sampleOd;
  // (RL4) signed overdrive offset times sample period
  // (RL6) closed loop handles overdrive itself, offset bypassed
  wire logic [HSL_DUR_W-1:0] next_odDur = openLoop ?
    adjDur(overdriveBase, overdriveOffset, samplePeriod) : overdriveBase;
  // (RL8) signed sustain offset times sample period
  wire logic [HSL_DUR_W-1:0] next_spDur = adjDur(posSustainBase, posSustainOffset,
                                                 samplePeriod);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      isOverdrive <= 1'b0;
      isPosSustain <= 1'b0;
      overdriveDuration <= HSL_DUR_ZERO;
      posSustainDuration <= HSL_DUR_ZERO;
    end else begin
      if (sampleValid) begin
        isOverdrive <= sampleOd;
        isPosSustain <= sampleSp;
      end
      overdriveDuration <= next_odDur;
      posSustainDuration <= next_spDur;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence sPassOver;
    endPass && state == HSL_PLAY;
  endsequence
  sequence sSlotAgain;
    state == HSL_WAIT && effectDone && !stopNow && repDone != curRep;
  endsequence

  chk_last_pass_done: assert property (sPassOver ##0 !morePasses |=> seqDone && !seqBusy) // RL1
    else $error("final pass did not finish sequence");
  chk_pass_restart: assert property (sPassOver ##0 (passCount != mainRepeatCount) // RL1
    |=> state == HSL_PLAY && slot == HSL_FIRST_SLOT)
    else $error("pass not restarted");
  chk_infinite_repeat: assert property (endPass && mainRepeatCount == HSL_MAIN_INFINITE // RL2
    |=> !seqDone)
    else $error("endless loop ended on its own");
  chk_stop_go: assert property (seqBusy && !goBit |=> !seqBusy) // RL2
    else $error("clearing start bit did not stop");
  chk_null_id_ends: assert property (state == HSL_PLAY && curId == HSL_NULL_ID && !stopNow // RL3
    |=> !effectStart)
    else $error("null identifier played");
  chk_slot_repeat: assert property (sSlotAgain // RL9
    |=> state == HSL_PLAY && slot == $past(slot)
    ##1 effectStart && effectId == $past(curId, 2))
    else $error("slot not replayed");
  chk_od_class: assert property (sampleValid && sampleValue == waveMax // RL5
    |=> isOverdrive && !isPosSustain)
    else $error("max sample not overdrive");
  chk_sustain_class: assert property (sampleValid && sampleValue > 0 // RL7
    && sampleValue != waveMax |=> isPosSustain)
    else $error("positive sample not sustain");
  chk_od_closed_loop: assert property (!openLoop // RL6
    |=> overdriveDuration == $past(overdriveBase))
    else $error("offset applied in closed loop");
  chk_od_offset_sign: assert property (openLoop && overdriveOffset < 0 // RL4
    |=> overdriveDuration <= $past(overdriveBase))
    else $error("negative overdrive offset lengthened");
  chk_sp_offset_sign: assert property (posSustainOffset >= 0 // RL8
    |=> posSustainDuration >= $past(posSustainBase))
    else $error("positive sustain offset shortened");
endmodule

//--- tb/test_haptic_seq_loop_time_offset.sv
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fail_count++; \
  $display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module test_haptic_seq_loop_time_offset;
  import hsl_pkg::*;
  logic clock = 0, rst_n = 0, regWrEn = 0, regRdEn = 0, goBit = 0, stopTrig = 0;
  logic effectDone = 0, openLoop = 0, sampleValid = 0;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, samplePeriod = 8'h04;
  logic [63:0] slotIdFlat = 64'h0;
  logic [15:0] slotRepFlat = 16'h0;
  logic signed [7:0] sampleValue = 8'sh00, waveMax = 8'sh64;
  logic [15:0] overdriveBase = 16'h0064, posSustainBase = 16'h0032;
  logic [15:0] overdriveDuration, posSustainDuration;
  logic effectStart, seqBusy, seqDone, isOverdrive, isPosSustain;
  logic [6:0] effectId;
  logic [2:0] slotIndex;
  int fail_count = 0, check_count = 0;
  always #10 clock = ~clock;
  hsl_seq_loop_offset DUT (.clock(clock), .rst_n(rst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .goBit(goBit), .stopTrig(stopTrig), .slotIdFlat(slotIdFlat), .slotRepFlat(slotRepFlat),
    .effectDone(effectDone), .effectStart(effectStart), .effectId(effectId),
    .slotIndex(slotIndex), .seqBusy(seqBusy), .seqDone(seqDone), .openLoop(openLoop),
    .samplePeriod(samplePeriod), .sampleValid(sampleValid), .sampleValue(sampleValue),
    .waveMax(waveMax), .isOverdrive(isOverdrive), .isPosSustain(isPosSustain),
    .overdriveBase(overdriveBase), .posSustainBase(posSustainBase),
    .overdriveDuration(overdriveDuration), .posSustainDuration(posSustainDuration));
  ////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // idle cycle after each strobe so no signal is set twice in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr = a; regWrData = d; regWrEn = 1;
    @(posedge clock); #1 regWrEn = 0;
    @(posedge clock); #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    regAddr = a; regRdEn = 1;
    @(posedge clock); #1 regRdEn = 0; d = regRdData;
    @(posedge clock); #1;
  endtask
  // plays until done or the stopAt-th start, answering each start
  task automatic run_seq(input logic [6:0] exp[$], input logic [2:0] sl[$], input int total,
                         input int stopAt, input bit useGo);
    int got;
    bit ended, dn, st;
    got = 0; ended = 0;
    @(posedge clock); #1 goBit = 1;
    for (int c = 0; c < 3000 && !ended; c++) begin
      @(posedge clock); #1;
      dn = 0; st = 0;
      if (seqDone === 1'b1) begin
        `CHK(got, total)
        `CHK(seqBusy, 1'b0)
        ended = 1;
      end else if (effectStart === 1'b1) begin
        `CHK(effectId, exp[got % exp.size()])
        `CHK(slotIndex, sl[got % sl.size()])
        `CHK(seqBusy, 1'b1)
        got++;
        if (got == stopAt) begin st = 1; ended = 1; end
        else dn = 1;
      end
      effectDone = dn;
      stopTrig = st && !useGo;
      if (st && useGo) goBit = 0;
    end
    if (!ended) begin fail_count++; report_and_stop; end
    for (int c = 0; c < 3; c++) begin
      @(posedge clock); #1 stopTrig = 0; effectDone = 0; goBit = 0;
      if (stopAt > 0) `CHK(seqDone, 1'b0)
    end
    `CHK(seqBusy, 1'b0)
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [7:0] d;
    rd(HSL_ADDR_SEQ_CTRL, d); `CHK(d, 8'h00)
    rd(HSL_ADDR_OD_OFFSET, d); `CHK(d, 8'h00)
    rd(HSL_ADDR_SP_OFFSET, d); `CHK(d, 8'h00)
    wr(HSL_ADDR_SEQ_CTRL, 8'hFF); rd(HSL_ADDR_SEQ_CTRL, d); `CHK(d, 8'hFF)
    wr(HSL_ADDR_OD_OFFSET, 8'hA5); rd(HSL_ADDR_OD_OFFSET, d); `CHK(d, 8'hA5)
    wr(HSL_ADDR_SP_OFFSET, 8'h5A); rd(HSL_ADDR_SP_OFFSET, d); `CHK(d, 8'h5A)
    wr(8'h1C, 8'h33); rd(8'h1C, d); `CHK(d, 8'h00)
  endtask
  task automatic t_loops;
    logic [6:0] ids[$];
    logic [2:0] sl[$];
    // slot0 twice, slot1 once, slot2 ends pass so slot3 never plays; three passes
    slotIdFlat = 64'h0000_0000_0B00_0905; slotRepFlat = 16'h0001;
    wr(HSL_ADDR_SEQ_CTRL, 8'h02);
    run_seq('{7'h05, 7'h05, 7'h09}, '{3'h0, 3'h0, 3'h1}, 9, 0, 0);
    // all eight slots, last one four times; single pass, then wrap into a second
    slotIdFlat = 64'h0807_0605_0403_0201; slotRepFlat = 16'hC000;
    ids = '{7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h06, 7'h07, 7'h08, 7'h08, 7'h08, 7'h08};
    sl = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h7, 3'h7, 3'h7};
    wr(HSL_ADDR_SEQ_CTRL, 8'h00);
    run_seq(ids, sl, 11, 0, 0);
    wr(HSL_ADDR_SEQ_CTRL, 8'h01);
    run_seq(ids, sl, 22, 0, 0);
    // endless: more passes than any finite count, stopped both ways
    slotIdFlat = 64'h0000_0000_0000_0003; slotRepFlat = 16'h0000;
    wr(HSL_ADDR_SEQ_CTRL, 8'h07);
    run_seq('{7'h03}, '{3'h0}, 0, 10, 0);
    run_seq('{7'h03}, '{3'h0}, 0, 10, 1);
  endtask
  task automatic t_offsets;
    wr(HSL_ADDR_OD_OFFSET, 8'h05); wr(HSL_ADDR_SP_OFFSET, 8'hF6);
    openLoop = 1; @(posedge clock); #1; @(posedge clock); #1;
    `CHK(overdriveDuration, 16'h0078)
    `CHK(posSustainDuration, 16'h000A)
    openLoop = 0; @(posedge clock); #1; @(posedge clock); #1;
    `CHK(overdriveDuration, 16'h0064)
    `CHK(posSustainDuration, 16'h000A)
    openLoop = 1; wr(HSL_ADDR_OD_OFFSET, 8'hE0); wr(HSL_ADDR_SP_OFFSET, 8'h80);
    `CHK(overdriveDuration, 16'h0000)
    `CHK(posSustainDuration, 16'h0000)
    // large base plus positive offset saturates instead of wrapping
    posSustainBase = 16'hFFF0; wr(HSL_ADDR_SP_OFFSET, 8'h7F);
    `CHK(posSustainDuration, 16'hFFFF)
  endtask
  task automatic t_classify;
    logic [7:0] v[3];
    logic [1:0] e[3];
    v = '{8'h64, 8'h28, 8'hEC};
    e = '{2'b10, 2'b01, 2'b00};
    for (int i = 0; i < 3; i++) begin
      sampleValue = v[i]; sampleValid = 1;
      @(posedge clock); #1 sampleValid = 0;
      `CHK({isOverdrive, isPosSustain}, e[i])
      sampleValue = 8'h64;
      @(posedge clock); #1;
      `CHK({isOverdrive, isPosSustain}, e[i])
    end
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clock);
    #1 rst_n = 1;
    t_regs;
    t_loops;
    t_offsets;
    t_classify;
    report_and_stop;
  end
endmodule
